// ==== core/lps_regs.svh ====
// Offsets, field positions, reset values and constant fields of the bank.
// Assumes 12-bit configuration byte offsets and 32-bit words.
`ifndef LPS_REGS_SVH
`define LPS_REGS_SVH

// ******************************
// Register offsets
// ******************************
`define LPS_OFF_LTR_HDR   12'h230
`define LPS_OFF_LATENCY   12'h234
`define LPS_OFF_L1_HDR    12'h240
`define LPS_OFF_L1_CAP    12'h244
`define LPS_OFF_L1_CTL1   12'h248
`define LPS_OFF_L1_CTL2   12'h24c
`define LPS_OFF_LTSSM     12'h33c
`define LPS_OFF_HOTINS    12'h340
`define LPS_OFF_SBCTL     12'h344

// ******************************
// Capability header constants
// ******************************
`define LPS_LTR_CAP_ID    16'h0018
`define LPS_L1_CAP_ID     16'h001e
`define LPS_CAP_VER       4'h1
`define LPS_LTR_NEXT      12'h240
`define LPS_L1_NEXT       12'h000

// ******************************
// Field positions
// ******************************
`define LPS_PM11_BIT      1
`define LPS_ASPM11_BIT    3
`define LPS_L1SS_BIT      4
`define LPS_SBMODE_BIT    0
`define LPS_PECDIS_BIT    9
`define LPS_PECFAIL_BIT   29
`define LPS_UNSUP_BIT     30

// ******************************
// Reset values and masks
// ******************************
`define LPS_LAT_RST       13'h0000
`define LPS_LAT_MASK      32'h1fff_1fff
`define LPS_PM11SUP_RST   1'b1
`define LPS_ASPM11SUP_RST 1'b0
`define LPS_L1SS_RST      1'b1
`define LPS_CTL2_VAL      32'h0000_0000
`define LPS_LTSSM_RST     8'h00
`define LPS_HOTINS_RST    16'h0000
`define LPS_LLSW_RST      16'h0004
`define LPS_SBMODE_RST    1'b1
`define LPS_SBADDR_HI_RST 4'hd
`define LPS_SBADDR_LO_RST 3'h0
`define LPS_PECDIS_RST    1'b1

`endif

// ==== core/lps_pkg.sv ====
// Types shared by the configuration bank and its users.
// Assumes the constants header is included where offsets are needed.
package lps_pkg;

   // ******************************
   // Carriers
   // ******************************
   typedef struct packed {
      logic [11:0] addr;
      logic        wr;
      logic        rd;
      logic [3:0]  be;
      logic [31:0] wdata;
   } lps_cfg_req_t;

   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
      logic [31:0] data;
   } lps_load_t;

   typedef struct packed {
      logic [9:0] snoopVal;
      logic [2:0] snoopScale;
      logic [9:0] nosnoopVal;
      logic [2:0] nosnoopScale;
      logic       pmL11En;
      logic       aspmL11En;
      logic       smbusMode;
      logic [6:0] slaveAddr;
      logic       pecCheckEn;
   } lps_ctrl_t;

   // ******************************
   // Strap capture states
   // ******************************
   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_STRAP = 3'b010,
      ST_RUN   = 3'b100
   } lps_strap_st_t;

endpackage

// ==== core/lps_config_regs.sv ====
// Latency tolerance, L1 substates, status words and sideband control.
// Assumes a config port and a sideband/EEPROM loader on the core clock.
`timescale 1ns/1ns
`include "lps_regs.svh"

module lps_config_regs #(
   parameter bit UPSTREAM_PORT = 1'b1
) (
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   input  wire lps_pkg::lps_cfg_req_t cfgReq,
   output logic [31:0]               cfgRdData,
   output logic                      cfgRdValid,
   input  wire lps_pkg::lps_load_t   sbLoad,
   input  wire logic [2:0]           addrStrapPin,
   input  wire logic                 pecFailEvt,
   input  wire logic                 unsupCmdEvt,
   output lps_pkg::lps_ctrl_t        ctrl
);
   import lps_pkg::*;

   // ******************************
   // Helpers
   // ******************************
   function automatic logic [31:0] mergeBytes(
      input logic [31:0] oldVal,
      input logic [31:0] newVal,
      input logic [3:0]  be,
      input logic [31:0] mask
   );
      logic [31:0] res;
      res = oldVal;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = newVal[i*8 +: 8];
         end
      end
      return (res & mask) | (oldVal & ~mask);
   endfunction

   function automatic logic [31:0] capHeader(
      input logic [11:0] nextPtr,
      input logic [15:0] capId
   );
      return {nextPtr, `LPS_CAP_VER, capId};
   endfunction

   // ******************************
   // State
   // ******************************
   logic [12:0]   snoopLat;
   logic [12:0]   nosnoopLat;
   logic          pm11Sup;
   logic          aspm11Sup;
   logic          l1ssSup;
   logic          pmL11En;
   logic          aspmL11En;
   logic [7:0]    ltssmStat;
   logic [15:0]   hotInsStat;
   logic [15:0]   llStatWord;
   logic          smbusMode;
   logic [6:0]    slaveAddr;
   logic          pecDisable;
   logic          pecFail;
   logic          unsupCmd;
   logic [12:0]   next_snoopLat;
   logic [12:0]   next_nosnoopLat;
   logic          next_pm11Sup;
   logic          next_aspm11Sup;
   logic          next_l1ssSup;
   logic          next_pmL11En;
   logic          next_aspmL11En;
   logic [7:0]    next_ltssmStat;
   logic [15:0]   next_hotInsStat;
   logic [15:0]   next_llStatWord;
   logic          next_smbusMode;
   logic [6:0]    next_slaveAddr;
   logic          next_pecDisable;
   logic          next_pecFail;
   logic          next_unsupCmd;
   logic [31:0]   rdMux;
   logic [31:0]   sbCtlWord;
   logic [31:0]   latWord;
   logic [31:0]   mergedLat;
   logic [31:0]   mergedSb;
   logic          wrLat;
   logic          wrCtl1;
   logic          wrSb;
   logic [2:0]    strapS1;
   logic [2:0]    strapS2;
   logic [2:0]    strapS3;
   lps_strap_st_t strapSt;
   lps_strap_st_t next_strapSt;
   logic          strapTake;

   // ******************************
   // Strap synchroniser and capture
   // ******************************
   // Straps are pins: three stages, taken once two stages agree
   always_ff @(posedge mclk) begin
      strapS1 <= addrStrapPin;
      strapS2 <= strapS1;
      strapS3 <= strapS2;
   end

   always_comb begin
      next_strapSt = strapSt;
      strapTake    = 1'b0;
      case (strapSt)
         ST_RESET: begin
            next_strapSt = ST_STRAP;
         end
         ST_STRAP: begin
            if (strapS2 == strapS3) begin
               strapTake    = 1'b1;
               next_strapSt = ST_RUN;
            end
         end
         ST_RUN: begin
            next_strapSt = ST_RUN;
         end
         default: begin
            next_strapSt = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         strapSt <= ST_RESET;
      end else begin
         strapSt <= next_strapSt;
      end
   end

   // ******************************
   // Register next values
   // ******************************
   assign latWord   = {3'h0, nosnoopLat, 3'h0, snoopLat};
   assign sbCtlWord = {1'b0, unsupCmd, pecFail, 19'h0, pecDisable,
                       1'b0, slaveAddr, smbusMode};
   // Downstream ports ignore writes to upstream-only registers
   assign wrLat  = cfgReq.wr && UPSTREAM_PORT &&
                   cfgReq.addr == `LPS_OFF_LATENCY;
   assign wrCtl1 = cfgReq.wr && cfgReq.addr == `LPS_OFF_L1_CTL1;
   assign wrSb   = cfgReq.wr && UPSTREAM_PORT &&
                   cfgReq.addr == `LPS_OFF_SBCTL;
   assign mergedLat = mergeBytes(latWord, cfgReq.wdata, cfgReq.be,
                                 `LPS_LAT_MASK);
   assign mergedSb  = mergeBytes(sbCtlWord, cfgReq.wdata, cfgReq.be,
                                 32'h0000_02ff);

   always_comb begin
      next_snoopLat   = snoopLat;
      next_nosnoopLat = nosnoopLat;
      next_pm11Sup    = pm11Sup;
      next_aspm11Sup  = aspm11Sup;
      next_l1ssSup    = l1ssSup;
      next_pmL11En    = pmL11En;
      next_aspmL11En  = aspmL11En;
      next_ltssmStat  = ltssmStat;
      next_hotInsStat = hotInsStat;
      next_llStatWord = llStatWord;
      next_smbusMode  = smbusMode;
      next_slaveAddr  = slaveAddr;
      next_pecDisable = pecDisable;
      next_pecFail    = pecFail;
      next_unsupCmd   = unsupCmd;
      if (wrLat) begin
         next_snoopLat   = mergedLat[12:0];
         next_nosnoopLat = mergedLat[28:16];
      end
      if (wrCtl1 && cfgReq.be[0]) begin
         next_pmL11En   = cfgReq.wdata[`LPS_PM11_BIT];
         next_aspmL11En = cfgReq.wdata[`LPS_ASPM11_BIT];
      end
      // Read-only defaults change only through the sideband loader
      if (sbLoad.valid) begin
         case (sbLoad.addr)
            `LPS_OFF_L1_CAP: begin
               next_pm11Sup   = sbLoad.data[`LPS_PM11_BIT];
               next_aspm11Sup = sbLoad.data[`LPS_ASPM11_BIT];
               next_l1ssSup   = sbLoad.data[`LPS_L1SS_BIT];
            end
            `LPS_OFF_LTSSM: begin
               next_ltssmStat = sbLoad.data[7:0];
            end
            `LPS_OFF_HOTINS: begin
               next_hotInsStat = sbLoad.data[15:0];
               next_llStatWord = sbLoad.data[31:16];
            end
            default: begin
               next_ltssmStat = ltssmStat;
            end
         endcase
      end
      if (strapTake) begin
         next_slaveAddr[2:0] = strapS3;
      end
      if (wrSb) begin
         next_smbusMode  = mergedSb[`LPS_SBMODE_BIT];
         next_slaveAddr  = mergedSb[7:1];
         next_pecDisable = mergedSb[`LPS_PECDIS_BIT];
         if (cfgReq.be[3] && cfgReq.wdata[`LPS_PECFAIL_BIT]) begin
            next_pecFail = 1'b0;
         end
         if (cfgReq.be[3] && cfgReq.wdata[`LPS_UNSUP_BIT]) begin
            next_unsupCmd = 1'b0;
         end
      end
      // Set after clear, so a coincident event is never lost
      if (pecFailEvt && smbusMode && !pecDisable) begin
         next_pecFail = 1'b1;
      end
      if (unsupCmdEvt) begin
         next_unsupCmd = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         snoopLat   <= `LPS_LAT_RST;
         nosnoopLat <= `LPS_LAT_RST;
         pm11Sup    <= `LPS_PM11SUP_RST;
         aspm11Sup  <= `LPS_ASPM11SUP_RST;
         l1ssSup    <= `LPS_L1SS_RST;
         pmL11En    <= 1'b0;
         aspmL11En  <= 1'b0;
         ltssmStat  <= `LPS_LTSSM_RST;
         hotInsStat <= `LPS_HOTINS_RST;
         llStatWord <= `LPS_LLSW_RST;
         smbusMode  <= `LPS_SBMODE_RST;
         slaveAddr  <= {`LPS_SBADDR_HI_RST, `LPS_SBADDR_LO_RST};
         pecDisable <= `LPS_PECDIS_RST;
         pecFail    <= 1'b0;
         unsupCmd   <= 1'b0;
      end else begin
         snoopLat   <= next_snoopLat;
         nosnoopLat <= next_nosnoopLat;
         pm11Sup    <= next_pm11Sup;
         aspm11Sup  <= next_aspm11Sup;
         l1ssSup    <= next_l1ssSup;
         pmL11En    <= next_pmL11En;
         aspmL11En  <= next_aspmL11En;
         ltssmStat  <= next_ltssmStat;
         hotInsStat <= next_hotInsStat;
         llStatWord <= next_llStatWord;
         smbusMode  <= next_smbusMode;
         slaveAddr  <= next_slaveAddr;
         pecDisable <= next_pecDisable;
         pecFail    <= next_pecFail;
         unsupCmd   <= next_unsupCmd;
      end
   end

   // ******************************
   // Read path
   // ******************************
   // Unmapped and reserved space reads zero
   always_comb begin
      rdMux = 32'h0000_0000;
      case (cfgReq.addr)
         `LPS_OFF_LTR_HDR: begin
            if (UPSTREAM_PORT) begin
               rdMux = capHeader(`LPS_LTR_NEXT,
                                 `LPS_LTR_CAP_ID);
            end
         end
         `LPS_OFF_LATENCY: begin
            if (UPSTREAM_PORT) begin
               rdMux = latWord;
            end
         end
         `LPS_OFF_L1_HDR: begin
            rdMux = capHeader(`LPS_L1_NEXT, `LPS_L1_CAP_ID);
         end
         `LPS_OFF_L1_CAP: begin
            rdMux[`LPS_PM11_BIT]   = pm11Sup;
            rdMux[`LPS_ASPM11_BIT] = aspm11Sup;
            rdMux[`LPS_L1SS_BIT]   = l1ssSup;
         end
         `LPS_OFF_L1_CTL1: begin
            rdMux[`LPS_PM11_BIT]   = pmL11En;
            rdMux[`LPS_ASPM11_BIT] = aspmL11En;
         end
         `LPS_OFF_L1_CTL2: begin
            rdMux = `LPS_CTL2_VAL;
         end
         `LPS_OFF_LTSSM: begin
            rdMux[7:0] = ltssmStat;
         end
         `LPS_OFF_HOTINS: begin
            rdMux = {llStatWord, hotInsStat};
         end
         `LPS_OFF_SBCTL: begin
            if (UPSTREAM_PORT) begin
               rdMux = sbCtlWord;
            end
         end
         default: begin
            rdMux = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfgRdData  <= 32'h0000_0000;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdValid <= cfgReq.rd;
         if (cfgReq.rd) begin
            cfgRdData <= rdMux;
         end
      end
   end

   // ******************************
   // Control outputs
   // ******************************
   always_comb begin
      ctrl.snoopVal     = snoopLat[9:0];
      ctrl.snoopScale   = snoopLat[12:10];
      ctrl.nosnoopVal   = nosnoopLat[9:0];
      ctrl.nosnoopScale = nosnoopLat[12:10];
      ctrl.pmL11En      = pmL11En;
      ctrl.aspmL11En    = aspmL11En;
      ctrl.smbusMode    = smbusMode;
      ctrl.slaveAddr    = slaveAddr;
      ctrl.pecCheckEn   = ~pecDisable;
   end

   // ******************************
   // Assertions
   // ******************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_latWrite;
      cfgReq.wr && cfgReq.addr == `LPS_OFF_LATENCY && cfgReq.be == 4'hf;
   endsequence

   sequence s_latRead;
      cfgReq.rd && !cfgReq.wr && cfgReq.addr == `LPS_OFF_LATENCY;
   endsequence

   property p_ltr_header;
      cfgReq.rd && cfgReq.addr == `LPS_OFF_LTR_HDR |=> cfgRdValid &&
         cfgRdData == (UPSTREAM_PORT ? 32'h2401_0018 : 32'h0000_0000);
   endproperty
   a_ltr_header: assert property (p_ltr_header)
      else $error("latency header read wrong");

   property p_l1_header;
      cfgReq.rd && cfgReq.addr == `LPS_OFF_L1_HDR |=>
         cfgRdData == 32'h0001_001e;
   endproperty
   a_l1_header: assert property (p_l1_header)
      else $error("substates header read wrong");

   property p_ctl2_zero;
      cfgReq.rd && cfgReq.addr == `LPS_OFF_L1_CTL2 |=>
         cfgRdData == 32'h0000_0000;
   endproperty
   a_ctl2_zero: assert property (p_ctl2_zero)
      else $error("second control register not zero");

   // Downstream flavour must keep reading zero after the write
   property p_lat_roundtrip;
      s_latWrite ##1 s_latRead |=>
         cfgRdData == (UPSTREAM_PORT ?
                       ($past(cfgReq.wdata, 2) & 32'h1fff_1fff) :
                       32'h0000_0000);
   endproperty
   a_lat_roundtrip: assert property (p_lat_roundtrip)
      else $error("latency write not read back");

   sequence s_pecEvtThenRead;
      pecFailEvt && ctrl.smbusMode && ctrl.pecCheckEn ##1
         cfgReq.rd && cfgReq.addr == `LPS_OFF_SBCTL;
   endsequence

   property p_pec_set;
      s_pecEvtThenRead |=>
         cfgRdData[`LPS_PECFAIL_BIT] == UPSTREAM_PORT;
   endproperty
   a_pec_set: assert property (p_pec_set)
      else $error("check failure flag not set");

   property p_pec_gate;
      pecFailEvt && !(smbusMode && !pecDisable) && !pecFail |=> !pecFail;
   endproperty
   a_pec_gate: assert property (p_pec_gate)
      else $error("check failure flag set while gated off");

   property p_unsup_wins;
      unsupCmdEvt |=> unsupCmd [*1] ##0 sbCtlWord[`LPS_UNSUP_BIT];
   endproperty
   a_unsup_wins: assert property (p_unsup_wins)
      else $error("unsupported command flag lost");

   property p_w1c_zero_keeps;
      unsupCmd && wrSb && !cfgReq.wdata[`LPS_UNSUP_BIT] |=> unsupCmd;
   endproperty
   a_w1c_zero_keeps: assert property (p_w1c_zero_keeps)
      else $error("zero write cleared status");

   property p_reset_values;
      $fell(sys_rst) |-> smbusMode && pecDisable &&
         slaveAddr[6:3] == 4'hd && !pmL11En && llStatWord == 16'h0004;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("control reset values wrong");

   property p_strap_take;
      strapSt == ST_STRAP && strapS2 == strapS3 && !wrSb |=>
         slaveAddr[2:0] == $past(strapS3) && strapSt == ST_RUN;
   endproperty
   a_strap_take: assert property (p_strap_take)
      else $error("strap not captured into address");

   property p_cap_load;
      sbLoad.valid && sbLoad.addr == `LPS_OFF_L1_CAP |=>
         pm11Sup == $past(sbLoad.data[1]) &&
         l1ssSup == $past(sbLoad.data[4]);
   endproperty
   a_cap_load: assert property (p_cap_load)
      else $error("capability default not loaded");

endmodule

// ==== sim/lps_far_model.sv ====
// Sideband loader and event source facing the configuration bank.
// Assumes its tasks are called just after a rising mclk edge.
`timescale 1ns/1ns
module lps_far_model (
   input  wire logic          mclk,
   output lps_pkg::lps_load_t sbLoad,
   output logic               pecFailEvt,
   output logic               unsupCmdEvt
);
   import lps_pkg::*;

   initial begin
      sbLoad = '0;
      pecFailEvt = 1'b0;
      unsupCmdEvt = 1'b0;
   end

   // ******************************
   // Default load, optional idle gap
   // ******************************
   task automatic load(input logic [11:0] a, input logic [31:0] d,
                       input int gap);
      repeat (gap) @(posedge mclk);
      if (gap > 0) #1;
      sbLoad = '{valid: 1'b1, addr: a, data: d};
      @(posedge mclk);
      // Stale data turned over so nothing can lean on it
      #1 sbLoad = '{valid: 1'b0, addr: ~a, data: ~d};
   endtask

   // ******************************
   // One-cycle event pulses
   // ******************************
   task automatic pulse(input logic pec, input logic uns);
      pecFailEvt = pec;
      unsupCmdEvt = uns;
      @(posedge mclk);
      #1 pecFailEvt = 1'b0;
      unsupCmdEvt = 1'b0;
   endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the configuration bank, both port flavours.
// Assumes the bank and the far-side model share the 100 MHz mclk.
`timescale 1ns/1ns
module tb;
   import lps_pkg::*;

   logic         mclk;
   logic         sysRst;
   lps_cfg_req_t cfgReq;
   logic [31:0]  cfgRdData;
   logic         cfgRdValid;
   lps_load_t    sbLoad;
   logic [2:0]   strap;
   logic         pecFailEvt;
   logic         unsupCmdEvt;
   lps_ctrl_t    ctrl;
   logic [31:0]  expQ[$];
   logic [31:0]  dnQ[$];
   logic [31:0]  dnRdData;
   logic         dnRdValid;
   int           fails;
   int           cmpCount;
   int           cycles;
   logic [31:0]  d;
   logic [31:0]  e;
   logic [11:0]  tA [7] = '{12'h230, 12'h240, 12'h244, 12'h24c,
                            12'h33c, 12'h340, 12'h250};
   logic [31:0]  tE [7] = '{32'h2401_0018, 32'h0001_001e, 32'h0000_0012,
                            32'h0, 32'h0, 32'h0004_0000, 32'h0};

   lps_config_regs i_lps_config_regs (
      .mclk        (mclk),
      .sys_rst     (sysRst),
      .cfgReq      (cfgReq),
      .cfgRdData   (cfgRdData),
      .cfgRdValid  (cfgRdValid),
      .sbLoad      (sbLoad),
      .addrStrapPin(strap),
      .pecFailEvt  (pecFailEvt),
      .unsupCmdEvt (unsupCmdEvt),
      .ctrl        (ctrl)
   );

   // Downstream flavour shares every input with the upstream one
   lps_config_regs #(
      .UPSTREAM_PORT(1'b0)
   ) i_lps_config_regs_dn (
      .mclk        (mclk),
      .sys_rst     (sysRst),
      .cfgReq      (cfgReq),
      .cfgRdData   (dnRdData),
      .cfgRdValid  (dnRdValid),
      .sbLoad      (sbLoad),
      .addrStrapPin(strap),
      .pecFailEvt  (pecFailEvt),
      .unsupCmdEvt (unsupCmdEvt),
      .ctrl        ()
   );

   lps_far_model i_lps_far_model (
      .mclk       (mclk),
      .sbLoad     (sbLoad),
      .pecFailEvt (pecFailEvt),
      .unsupCmdEvt(unsupCmdEvt)
   );

   always #5 mclk = ~mclk;

   // ******************************
   // Checking helpers
   // ******************************
   function automatic void chk(input logic [31:0] got,
                               input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endfunction

   task automatic conclude();
      $display("Compares %0d, mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ******************************
   // Config port cycles
   // ******************************
   // Request stands until the next call or idle replaces it,
   // so no strobe is lowered and raised in one time step
   task automatic wr(input logic [11:0] a, input logic [31:0] v,
                     input logic [3:0] be);
      cfgReq = '{addr: a, wr: 1'b1, rd: 1'b0, be: be, wdata: v};
      @(posedge mclk);
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      expQ.push_back(exp);
      // Upstream-only words read zero on a downstream port
      dnQ.push_back((a == 12'h230 || a == 12'h234 || a == 12'h344) ?
                    32'h0 : exp);
      cfgReq = '{addr: a, wr: 1'b0, rd: 1'b1, be: 4'h0,
                 wdata: ~cfgReq.wdata};
      @(posedge mclk);
      #1;
   endtask

   task automatic idle();
      cfgReq = '{addr: cfgReq.addr, wr: 1'b0, rd: 1'b0, be: 4'h0,
                 wdata: cfgReq.wdata};
      @(posedge mclk);
      #1;
   endtask

   // Read data taken in the one cycle that valid stands
   always @(posedge mclk) begin
      if (cfgRdValid === 1'b1) begin
         if (expQ.size() == 0) begin
            fails++;
            $display("ERROR %0t: read data with nothing pending", $time);
         end else begin
            chk(cfgRdData, expQ.pop_front());
            chk(dnRdData, dnQ.pop_front());
            chk(32'(dnRdValid), 32'h1);
         end
      end
   end

   // Whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         $display("ERROR %0t: run did not finish", $time);
         conclude();
      end
   end

   // ******************************
   // Main sequence
   // ******************************
   initial begin
      mclk = 1'b0;
      sysRst = 1'b1;
      cfgReq = '0;
      fails = 0;
      cmpCount = 0;
      cycles = 0;
      d = $urandom(56083);
      strap = 3'($urandom());
      repeat (10) @(posedge mclk);
      #1 sysRst = 1'b0;
      repeat (8) @(posedge mclk);
      #1;

      for (int i = 0; i < 7; i++) rd(tA[i], tE[i]);
      rd(12'h234, 32'h0);
      rd(12'h248, 32'h0);
      rd(12'h344, {22'h0, 1'b1, 1'b0, 4'hd, strap, 1'b1});
      chk(32'(ctrl.smbusMode), 32'h1);
      chk(32'(ctrl.pecCheckEn), 32'h0);
      chk(32'(ctrl.slaveAddr), 32'({4'hd, strap}));
      $display("Test reset values done");

      // Read-only words keep their values under all-ones writes
      for (int i = 0; i < 7; i++) begin
         wr(tA[i], 32'hffff_ffff, 4'hf);
         rd(tA[i], tE[i]);
      end
      $display("Test read-only words done");

      d = $urandom();
      wr(12'h234, d, 4'hf);
      rd(12'h234, d & 32'h1fff_1fff);
      chk(32'(ctrl.snoopVal), 32'(d[9:0]));
      chk(32'(ctrl.snoopScale), 32'(d[12:10]));
      chk(32'(ctrl.nosnoopVal), 32'(d[25:16]));
      chk(32'(ctrl.nosnoopScale), 32'(d[28:26]));
      e = d & 32'h1fff_1fff;
      e[15:8] = ~d[15:8] & 8'h1f;
      wr(12'h234, ~d, 4'h2);
      rd(12'h234, e);
      $display("Test latency words done");

      wr(12'h248, 32'hffff_ffff, 4'hf);
      rd(12'h248, 32'h0000_000a);
      chk(32'({ctrl.pmL11En, ctrl.aspmL11En}), 32'h3);
      $display("Test substate enables done");

      d = $urandom();
      idle();
      i_lps_far_model.load(12'h244, d, 0);
      rd(12'h244, d & 32'h0000_001a);
      idle();
      i_lps_far_model.load(12'h33c, d, 2);
      rd(12'h33c, d & 32'h0000_00ff);
      idle();
      i_lps_far_model.load(12'h340, ~d, 0);
      rd(12'h340, ~d);
      $display("Test default loads done");

      wr(12'h344, 32'he000_0154, 4'hf);
      rd(12'h344, 32'h0000_0054);
      chk(32'({ctrl.smbusMode, ctrl.pecCheckEn}), 32'h1);
      chk(32'(ctrl.slaveAddr), 32'h2a);
      idle();
      i_lps_far_model.pulse(1'b1, 1'b0);
      rd(12'h344, 32'h0000_0054);
      wr(12'h344, 32'h0000_0055, 4'h3);
      idle();
      i_lps_far_model.pulse(1'b1, 1'b1);
      rd(12'h344, 32'h6000_0055);
      wr(12'h344, 32'h0000_0055, 4'hf);
      rd(12'h344, 32'h6000_0055);
      wr(12'h344, 32'h2000_0055, 4'hf);
      rd(12'h344, 32'h4000_0055);
      // Held write clears bit 30 on the event edge: the set must win
      wr(12'h344, 32'h4000_0255, 4'hf);
      i_lps_far_model.pulse(1'b1, 1'b1);
      rd(12'h344, 32'h4000_0255);
      chk(32'(ctrl.pecCheckEn), 32'h0);
      $display("Test sideband control done");

      idle();
      repeat (3) @(posedge mclk);
      chk(32'(expQ.size()), 32'h0);
      conclude();
   end
endmodule
